// >>> core/sfwd_pkg.sv
// Constants, field layouts and timing counts for the supervisor watchdog and reset block.
// Assumes a single 25 MHz system clock, from which every slower rate is derived.
// Functional notes
// [RQ1] Watchdog settings live in one register, 09h.
// [RQ2] Resolution codes: 1/16, 1/4, 1, 4 seconds.
// [RQ3] Period equals multiplier times resolution step.
// [RQ4] Expiry may be one step early or late.
// [RQ5] Unserviced expiry sets flag, then interrupt or reset.
// [RQ6] Top bit steers: 0 interrupt, 1 reset pulse.
// [RQ7] Reset-steered expiry clears watchdog and four control bits.
// [RQ8] Pin edge or register write restarts the period.
// [RQ9] Pin edge or 00h write clears interrupt, disables.
// [RQ10] Flags read clears flag, leaves interrupt asserted.
// [RQ11] Power-up clears register, watchdog starts disabled.
// [RQ12] Supply fail holds reset low, then recovery time.
// [RQ13] Power-on clears the listed control bits.
// [RQ14] Both reset inputs mimic a power-cycle reset.
// [RQ15] Reset-input pulses below minimum width are ignored.
// [RQ16] First input falling edge, second input rising edge.
// [RQ17] Reset released recovery time after input inactive.
// [RQ18] Recovery time chosen by select and stop bits.
// [RQ19] Sixteenth-second tick drives a down-counting multiplier.
package sfwd_pkg;
   localparam int unsigned CLK_MHZ          = 25;
   localparam int unsigned CLK_PERIOD_NS    = 40;
   // Register map and field layout.
   localparam int unsigned REG_W            = 8;
   localparam logic [7:0]  ADDR_WD_CFG      = 8'h09;
   localparam logic [7:0]  ADDR_FLAGS       = 8'h0f;
   localparam logic [7:0]  WD_CFG_RESET     = 8'h00;
   localparam int unsigned WD_STEER_BIT     = 7;
   localparam int unsigned WD_MULT_MSB      = 6;
   localparam int unsigned WD_MULT_LSB      = 2;
   localparam int unsigned WD_RES_MSB       = 1;
   localparam int unsigned WD_RES_LSB       = 0;
   localparam int unsigned FLAG_WD_BIT      = 7;
   // Loose control bits, one vector.
   localparam int unsigned AUX_W            = 9;
   localparam int unsigned AUX_FREQ_TEST    = 0;
   localparam int unsigned AUX_ALARM_IRQ    = 1;
   localparam int unsigned AUX_ALARM_BACKUP = 2;
   localparam int unsigned AUX_SQUARE_WAVE  = 3;
   localparam int unsigned AUX_OSC_FAIL_IRQ = 4;
   localparam int unsigned AUX_TIE_A        = 5;
   localparam int unsigned AUX_TIE_B        = 6;
   localparam int unsigned AUX_REC_SEL      = 7;
   localparam int unsigned AUX_OSC_STOP     = 8;
   localparam logic [8:0]  AUX_RESET        = 9'h000;
   localparam logic [8:0]  AUX_WD_CLR_MASK  = 9'h00f;
   // Resolution step lengths in sixteenth-second ticks.
   localparam logic [6:0]  STEP_R0          = 7'h01;
   localparam logic [6:0]  STEP_R1          = 7'h04;
   localparam logic [6:0]  STEP_R2          = 7'h10;
   localparam logic [6:0]  STEP_R3          = 7'h40;
   // Times in their own units and the derived cycle counts.
   localparam int unsigned T_BASE_TICK_US   = 62500;
   localparam int unsigned T_TREC_STD_MS    = 96;
   localparam int unsigned T_TREC_STOP_MS   = 100;
   localparam int unsigned T_TREC_FAST_US   = 1000;
   localparam int unsigned T_MIN_PULSE_NS   = 150;
   localparam int unsigned BASE_TICK_CYC    = T_BASE_TICK_US * CLK_MHZ;
   localparam int unsigned TREC_STD_CYC     = T_TREC_STD_MS * 1000 * CLK_MHZ;
   localparam int unsigned TREC_STOP_CYC    = T_TREC_STOP_MS * 1000 * CLK_MHZ;
   localparam int unsigned TREC_FAST_CYC    = T_TREC_FAST_US * CLK_MHZ;
   localparam int unsigned MIN_PULSE_CYC    = (T_MIN_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned BASE_CNT_W       = 21;
   localparam int unsigned TREC_CNT_W       = 22;
   localparam logic [1:0]  PIN_IDLE         = 2'b11;

   typedef enum logic [1:0]
   {
      WD_IDLE = 2'b00,
      WD_RUN  = 2'b01,
      WD_IRQ  = 2'b11
   } sfwd_wd_state_t;
endpackage

// >>> core/sfwd_pin_filter.sv
// Synchroniser and width filter for one reset input pin.
// Assumes the pin is asynchronous to the system clock and idles at the given level.
`timescale 1ns/1ps
module sfwd_pin_filter
#(
   parameter logic P_IDLE = 1'b1
)
(
   input  wire logic i_sys_clk,
   input  wire logic i_rst_b,
   input  wire logic i_pin,
   output logic      o_level
);
   import sfwd_pkg::*;

   logic       sync1_ff;
   logic       sync2_ff;
   logic [2:0] stable_ff;
   logic       level_ff;

   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         sync1_ff <= P_IDLE;
         sync2_ff <= P_IDLE;
      end
      else
      begin
         sync1_ff <= i_pin;
         sync2_ff <= sync1_ff;
      end
   end

   // A new level must persist for the whole minimum width before it is believed.
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         stable_ff <= 3'h0;
         level_ff  <= P_IDLE;
      end
      else if (sync2_ff == level_ff)
      begin
         stable_ff <= 3'h0;
      end
      else if (stable_ff == 3'(MIN_PULSE_CYC - 1))
      begin
         stable_ff <= 3'h0;
         level_ff  <= sync2_ff; // RQ15
      end
      else
      begin
         stable_ff <= stable_ff + 3'h1;
      end
   end

   assign o_level = level_ff;

   AST_FILTER_WIDTH: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RQ15
      (level_ff != $past(level_ff)) |-> ($past(sync2_ff, 1) == level_ff
                                          && $past(sync2_ff, 4) == level_ff))
      else $error("Filtered reset input changed on a short pulse.");
endmodule

// >>> core/sfwd_supervisor.sv
// Watchdog timer, power-on reset and external reset sequencer of the supervisor.
// Assumes host register accesses arrive as single-cycle strobes on the system clock,
// and that the pins are asynchronous and are synchronised here.
`timescale 1ns/1ps
module sfwd_supervisor
#(
   parameter int unsigned P_BASE_TICK_CYC = sfwd_pkg::BASE_TICK_CYC,
   parameter int unsigned P_TREC_STD_CYC  = sfwd_pkg::TREC_STD_CYC,
   parameter int unsigned P_TREC_STOP_CYC = sfwd_pkg::TREC_STOP_CYC,
   parameter int unsigned P_TREC_FAST_CYC = sfwd_pkg::TREC_FAST_CYC
)
(
   input  wire logic                        i_sys_clk,
   input  wire logic                        i_rst_b,
   input  wire logic                        i_service_input_pin,
   input  wire logic                        i_reset_in_falling,
   input  wire logic                        i_reset_in_rising,
   input  wire logic                        i_supply_fail_trip,
   input  wire logic                        i_reg_wr,
   input  wire logic                        i_reg_rd,
   input  wire logic [7:0]                  i_reg_addr,
   input  wire logic [sfwd_pkg::REG_W-1:0]  i_reg_wdata,
   input  wire logic                        i_aux_wr,
   input  wire logic [sfwd_pkg::AUX_W-1:0]  i_aux_wdata,
   output logic      [sfwd_pkg::REG_W-1:0]  o_reg_rdata,
   output logic      [sfwd_pkg::AUX_W-1:0]  o_aux_bits,
   output logic                             o_irq_out,
   output logic                             o_irq_oe_b,
   output logic                             o_rst_out,
   output logic                             o_rst_oe_b
);
   import sfwd_pkg::*;

   function automatic logic [6:0] step_len(input logic [1:0] res);
      case (res)
         2'b00:   step_len = STEP_R0;
         2'b01:   step_len = STEP_R1;
         2'b10:   step_len = STEP_R2;
         default: step_len = STEP_R3;
      endcase
   endfunction

   function automatic logic [TREC_CNT_W-1:0] trec_len(input logic rec_sel, input logic osc_stop);
      if (rec_sel)
         trec_len = TREC_CNT_W'(P_TREC_FAST_CYC);
      else if (osc_stop)
         trec_len = TREC_CNT_W'(P_TREC_STOP_CYC);
      else
         trec_len = TREC_CNT_W'(P_TREC_STD_CYC);
   endfunction

   logic [REG_W-1:0]      wd_cfg_ff;
   logic [AUX_W-1:0]      aux_ff;
   logic                  flag_ff;
   logic [REG_W-1:0]      rdata_ff;
   sfwd_wd_state_t        state_ff;
   sfwd_wd_state_t        nxt_state;
   logic [4:0]            wd_cnt_ff;
   logic [6:0]            pre_cnt_ff;
   logic [BASE_CNT_W-1:0] base_cnt_ff;
   logic                  base_tick;
   logic                  step_tick;
   logic                  timeout;
   logic                  wd_reset_req;
   logic                  cfg_write;
   logic                  flag_read;
   logic                  restart;
   logic [4:0]            cfg_mult;
   logic [1:0]            cfg_res;
   logic                  svc_s1_ff;
   logic                  svc_s2_ff;
   logic                  svc_s3_ff;
   logic                  svc_edge;
   logic                  pf_s1_ff;
   logic                  pf_s2_ff;
   logic [1:0]            rin_level;
   logic                  rin2_prev_ff;
   logic                  rin2_rise;
   logic                  por_pend_ff;
   logic                  rst_src;
   logic [TREC_CNT_W-1:0] rec_cnt_ff;
   logic                  irq_oe_b_ff;
   logic                  rst_oe_b_ff;

   assign cfg_write = i_reg_wr && (i_reg_addr == ADDR_WD_CFG); // RQ1
   assign flag_read = i_reg_rd && (i_reg_addr == ADDR_FLAGS);
   assign cfg_mult  = wd_cfg_ff[WD_MULT_MSB:WD_MULT_LSB];
   assign cfg_res   = wd_cfg_ff[WD_RES_MSB:WD_RES_LSB];

   // Pin synchronisers; the second stages feed the logic, and the service pin's third stage feeds its edge detector.
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         svc_s1_ff <= 1'b0;
         svc_s2_ff <= 1'b0;
         svc_s3_ff <= 1'b0;
         pf_s1_ff  <= 1'b0;
         pf_s2_ff  <= 1'b0;
      end
      else
      begin
         svc_s1_ff <= i_service_input_pin;
         svc_s2_ff <= svc_s1_ff;
         svc_s3_ff <= svc_s2_ff;
         pf_s1_ff  <= i_supply_fail_trip;
         pf_s2_ff  <= pf_s1_ff;
      end
   end

   assign svc_edge = svc_s2_ff ^ svc_s3_ff; // RQ8

   // Free-running sixteenth-second tick. It is not restarted by a service, which is the
   // source of the allowed one-step error and saves a reload path on a wide counter.
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         base_cnt_ff <= '0;
      else if (base_tick)
         base_cnt_ff <= '0;
      else
         base_cnt_ff <= base_cnt_ff + 1'b1; // RQ19
   end

   assign base_tick = (base_cnt_ff == BASE_CNT_W'(P_BASE_TICK_CYC - 1)); // RQ19 RQ4
   assign step_tick = base_tick && (pre_cnt_ff == step_len(cfg_res) - 7'h01); // RQ2
   assign timeout   = (state_ff == WD_RUN) && step_tick && (wd_cnt_ff == 5'h01); // RQ3 RQ5
   assign wd_reset_req = timeout && wd_cfg_ff[WD_STEER_BIT]; // RQ6
   assign restart   = cfg_write || (svc_edge && (state_ff == WD_RUN)); // RQ8

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         WD_IDLE:
         begin
            if (cfg_write && (i_reg_wdata[WD_MULT_MSB:WD_MULT_LSB] != 5'h00))
               nxt_state = WD_RUN;
         end
         WD_RUN:
         begin
            if (timeout)
               nxt_state = wd_cfg_ff[WD_STEER_BIT] ? WD_IDLE : WD_IRQ; // RQ6
            else if (cfg_write && (i_reg_wdata[WD_MULT_MSB:WD_MULT_LSB] == 5'h00))
               nxt_state = WD_IDLE;
         end
         WD_IRQ:
         begin
            if (svc_edge)
               nxt_state = WD_IDLE; // RQ9
            else if (cfg_write)
               nxt_state = (i_reg_wdata[WD_MULT_MSB:WD_MULT_LSB] == 5'h00) ? WD_IDLE : WD_RUN;
         end
         default:
            nxt_state = WD_IDLE;
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         state_ff    <= WD_IDLE; // RQ11
         irq_oe_b_ff <= 1'b1;
      end
      else
      begin
         state_ff    <= nxt_state;
         irq_oe_b_ff <= (nxt_state != WD_IRQ); // RQ6 RQ9 RQ10
      end
   end

   // Countdown of resolution steps from the programmed multiplier.
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         wd_cnt_ff  <= 5'h00;
         pre_cnt_ff <= 7'h00;
      end
      else if (cfg_write)
      begin
         wd_cnt_ff  <= i_reg_wdata[WD_MULT_MSB:WD_MULT_LSB]; // RQ8
         pre_cnt_ff <= 7'h00;
      end
      else if (restart)
      begin
         wd_cnt_ff  <= cfg_mult; // RQ8
         pre_cnt_ff <= 7'h00;
      end
      else if (step_tick)
      begin
         wd_cnt_ff  <= wd_cnt_ff - 5'h01; // RQ19
         pre_cnt_ff <= 7'h00;
      end
      else if (base_tick)
      begin
         pre_cnt_ff <= pre_cnt_ff + 7'h01;
      end
   end

   // A reset-steered expiry wins over a write landing in the same cycle.
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         wd_cfg_ff <= WD_CFG_RESET; // RQ11 RQ13
      else if (wd_reset_req)
         wd_cfg_ff <= WD_CFG_RESET; // RQ7
      else if (cfg_write)
         wd_cfg_ff <= i_reg_wdata; // RQ1
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         aux_ff <= AUX_RESET; // RQ13
      else if (wd_reset_req)
         aux_ff <= aux_ff & ~AUX_WD_CLR_MASK; // RQ7
      else if (i_aux_wr)
         aux_ff <= i_aux_wdata;
   end

   // Expiry beats a flags read in the same cycle so the event is never lost.
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         flag_ff <= 1'b0;
      else if (timeout)
         flag_ff <= 1'b1; // RQ5
      else if (flag_read)
         flag_ff <= 1'b0; // RQ10
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         rdata_ff <= 8'h00;
      else if (i_reg_rd)
      begin
         if (i_reg_addr == ADDR_WD_CFG)
            rdata_ff <= wd_cfg_ff;
         else if (i_reg_addr == ADDR_FLAGS)
            rdata_ff <= {flag_ff, 7'h00};
         else
            rdata_ff <= 8'h00;
      end
   end

   // Reset inputs; both idle high behind their pull-ups.
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_rin
         sfwd_pin_filter #(.P_IDLE(PIN_IDLE[gi])) u_filter
         (
            .i_sys_clk (i_sys_clk),
            .i_rst_b   (i_rst_b),
            .i_pin     ((gi == 0) ? i_reset_in_falling : i_reset_in_rising),
            .o_level   (rin_level[gi])
         );
      end
   endgenerate

   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         rin2_prev_ff <= 1'b1;
      else
         rin2_prev_ff <= rin_level[1];
   end

   assign rin2_rise = rin_level[1] && !rin2_prev_ff; // RQ16

   // The power-on pulse is started by the first clock after release, since an
   // asynchronous reset may only load constants.
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         por_pend_ff <= 1'b1;
      else
         por_pend_ff <= 1'b0;
   end

   assign rst_src = por_pend_ff || pf_s2_ff || !rin_level[0] || rin2_rise // RQ12 RQ14 RQ16
                    || wd_reset_req; // RQ6

   // Any source reloads the recovery count; the pin stays low until it drains.
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         rec_cnt_ff <= '0;
      else if (rst_src)
         rec_cnt_ff <= trec_len(aux_ff[AUX_REC_SEL], aux_ff[AUX_OSC_STOP]); // RQ17 RQ18
      else if (rec_cnt_ff != '0)
         rec_cnt_ff <= rec_cnt_ff - 1'b1; // RQ17
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         rst_oe_b_ff <= 1'b0; // RQ12
      else
         rst_oe_b_ff <= !(rst_src || (rec_cnt_ff > TREC_CNT_W'(1))); // RQ14 RQ17
   end

   assign o_reg_rdata = rdata_ff;
   assign o_aux_bits  = aux_ff;
   assign o_irq_out   = 1'b0;
   assign o_irq_oe_b  = irq_oe_b_ff;
   assign o_rst_out   = 1'b0;
   assign o_rst_oe_b  = rst_oe_b_ff;

   AST_CFG_LOAD: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RQ8
      (cfg_write && !timeout && i_reg_wdata[WD_MULT_MSB:WD_MULT_LSB] != 5'h00)
      |=> (wd_cnt_ff == $past(i_reg_wdata[WD_MULT_MSB:WD_MULT_LSB])) && state_ff == WD_RUN
          && pre_cnt_ff == 7'h00)
      else $error("Watchdog write did not restart the period.");

   AST_SVC_RESTART: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RQ8
      (svc_edge && state_ff == WD_RUN && !cfg_write && !timeout)
      |=> wd_cnt_ff == cfg_mult && pre_cnt_ff == 7'h00)
      else $error("Service edge did not restart the period.");

   AST_STEP_LEN: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RQ2
      (step_tick && state_ff == WD_RUN) |-> pre_cnt_ff == step_len(cfg_res) - 7'h01)
      else $error("Resolution step has the wrong length.");

   AST_FLAG_SET: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RQ5
      timeout |=> flag_ff)
      else $error("Expiry did not set the watchdog flag.");

   AST_IRQ_ON_EXPIRY: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RQ6
      (timeout && !wd_cfg_ff[WD_STEER_BIT]) |-> !wd_reset_req
                                              ##1 (!o_irq_oe_b && state_ff == WD_IRQ))
      else $error("Interrupt-steered expiry did not assert the interrupt.");

   AST_RST_ON_EXPIRY: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RQ6
      wd_reset_req |=> !o_rst_oe_b ##1 !o_rst_oe_b)
      else $error("Reset-steered expiry did not pull the reset low.");

   AST_EXPIRY_CLEAR: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RQ7
      wd_reset_req |=> wd_cfg_ff == 8'h00 && (aux_ff & AUX_WD_CLR_MASK) == 9'h000
                       && state_ff == WD_IDLE && o_irq_oe_b)
      else $error("Reset-steered expiry left settings uncleared.");

   AST_IRQ_CLEAR: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RQ9
      (state_ff == WD_IRQ && (svc_edge || cfg_write && i_reg_wdata == 8'h00))
      |=> o_irq_oe_b && state_ff == WD_IDLE)
      else $error("Interrupt was not cleared by service or 00h write.");

   AST_FLAG_READ: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RQ10
      (flag_read && !timeout && state_ff == WD_IRQ && !svc_edge && !cfg_write)
      |=> !flag_ff && !o_irq_oe_b)
      else $error("Flags read mishandled flag or interrupt.");

   AST_RSTIN_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RQ14
      (!rin_level[0] || rin2_rise || pf_s2_ff) |=> !o_rst_oe_b)
      else $error("Reset source did not drive the reset output.");

   AST_REC_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RQ17
      (!rst_src && rec_cnt_ff > TREC_CNT_W'(2)) |=> !o_rst_oe_b && rec_cnt_ff == $past(rec_cnt_ff) - 1'b1)
      else $error("Reset released before the recovery time ran out.");

   AST_REC_SELECT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // RQ18
      rst_src |=> rec_cnt_ff == trec_len($past(aux_ff[AUX_REC_SEL]), $past(aux_ff[AUX_OSC_STOP])))
      else $error("Recovery time does not follow select and stop bits.");

   COV_IRQ_EXPIRY: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      timeout && !wd_cfg_ff[WD_STEER_BIT]);

   COV_RST_EXPIRY: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      wd_reset_req);

   COV_FLAG_READ: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      flag_read && flag_ff);

   COV_EXT_RESET: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      rin2_rise ##1 !rin_level[0]);
endmodule

// >>> sim/sfwd_host_model.sv
// Host processor model: services the watchdog through its service pin.
// Assumes service requests arrive as one-cycle pulses on the system clock.
`timescale 1ns/1ps
module sfwd_host_model
(
   input  wire logic i_sys_clk,
   input  wire logic i_rst_b,
   input  wire logic i_kick,
   output logic      o_service_input_pin
);
   // Either edge services, so a toggle makes every request exactly one edge.
   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_service_input_pin <= 1'b0;
      end
      else if (i_kick)
      begin
         o_service_input_pin <= ~o_service_input_pin;
      end
   end
endmodule

// >>> sim/tb.sv
// Self-checking bench for the supervisor: watchdog, recovery timing and reset inputs.
// Assumes shortened timing parameters; every expectation is derived from them.
`timescale 1ns/1ps
module tb;
   import sfwd_pkg::*;
   localparam int TICK  = 16;
   localparam int TSTD  = 50;
   localparam int TSTOP = 60;
   localparam int TFAST = 20;
   logic             i_sys_clk          = 1'b0;
   logic             i_rst_b            = 1'b0;
   logic             kick               = 1'b0;
   logic             i_reset_in_falling = 1'b1;
   logic             i_reset_in_rising  = 1'b1;
   logic             i_supply_fail_trip = 1'b0;
   logic             i_reg_wr           = 1'b0;
   logic             i_reg_rd           = 1'b0;
   logic             i_aux_wr           = 1'b0;
   logic [7:0]       i_reg_addr         = 8'h00;
   logic [7:0]       i_reg_wdata        = 8'h00;
   logic [8:0]       i_aux_wdata        = 9'h000;
   logic             svc_pin;
   logic [7:0]       rd_val;
   logic [8:0]       aux;
   logic [8:0]       o_aux_bits;
   logic [7:0]       o_reg_rdata;
   logic             o_irq_out;
   logic             o_irq_oe_b;
   logic             o_rst_out;
   logic             o_rst_oe_b;
   int               err_total  = 0;
   int               num_checks = 0;
   int               seed       = 3;
   int               n;
   int               m;
   int               mult;
   // Both outputs are open drain with pull-ups.
   wire irq_pin = o_irq_oe_b ? 1'b1 : o_irq_out;
   wire rst_pin = o_rst_oe_b ? 1'b1 : o_rst_out;

   always #20 i_sys_clk = ~i_sys_clk;

   sfwd_host_model u_host (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_kick(kick),
      .o_service_input_pin(svc_pin));

   sfwd_supervisor #(.P_BASE_TICK_CYC(TICK), .P_TREC_STD_CYC(TSTD),
      .P_TREC_STOP_CYC(TSTOP), .P_TREC_FAST_CYC(TFAST)) u_dut (
      .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_service_input_pin(svc_pin),
      .i_reset_in_falling(i_reset_in_falling), .i_reset_in_rising(i_reset_in_rising),
      .i_supply_fail_trip(i_supply_fail_trip), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
      .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_aux_wr(i_aux_wr),
      .i_aux_wdata(i_aux_wdata), .o_reg_rdata(o_reg_rdata), .o_aux_bits(o_aux_bits),
      .o_irq_out(o_irq_out), .o_irq_oe_b(o_irq_oe_b), .o_rst_out(o_rst_out),
      .o_rst_oe_b(o_rst_oe_b));

   task cyc(input int k);
      repeat (k) @(posedge i_sys_clk);
      #1;
   endtask

   task finish_test();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      i_reg_wr = 1'b1;
      i_reg_addr = a;
      i_reg_wdata = d;
      cyc(1);
      i_reg_wr = 1'b0;
      cyc(1);
   endtask

   task rd(input logic [7:0] a);
      i_reg_rd = 1'b1;
      i_reg_addr = a;
      cyc(1);
      i_reg_rd = 1'b0;
      rd_val = o_reg_rdata;
      cyc(1);
   endtask

   task kick_pin();
      kick = 1'b1;
      cyc(1);
      kick = 1'b0;
   endtask

   task set_aux(input logic [8:0] v);
      i_aux_wr = 1'b1;
      i_aux_wdata = v;
      cyc(1);
      i_aux_wr = 1'b0;
   endtask

   // Bounded wait for a pin to go low; running out ends the run as a failure.
   task wait_lo(input bit r, output int k);
      k = 0;
      while ((r ? rst_pin : irq_pin) !== 1'b0)
      begin
         cyc(1);
         k++;
         if (k > 8000)
         begin
            err_total++;
            finish_test();
         end
      end
   endtask

   task low_len(output int k);
      k = 0;
      while (rst_pin === 1'b0)
      begin
         cyc(1);
         k++;
         if (k > 8000)
         begin
            err_total++;
            finish_test();
         end
      end
   endtask

   task drv(input int k, input logic act);
      if (k == 0)
         i_reset_in_falling = ~act;
      else if (k == 1)
         i_reset_in_rising = ~act;
      else
         i_supply_fail_trip = act;
   endtask

   function automatic int step_cyc(input logic [1:0] res);
      return TICK << (2 * res);
   endfunction

   function automatic int rec_cyc(input logic [8:0] a);
      return a[7] ? TFAST : (a[8] ? TSTOP : TSTD);
   endfunction

   initial
   begin
      repeat (4) @(posedge i_sys_clk);
      #1;
      i_rst_b = 1'b1;
      low_len(n);
      chk(n >= TSTD - 1 && n <= TSTD + 3, 1);
      chk(o_aux_bits, 9'h000);
      rd(ADDR_WD_CFG);
      chk(rd_val, 8'h00);
      rd(8'h3c);
      chk(rd_val, 8'h00);
      for (int r = 0; r < 4; r++)
      begin
         mult = ({$random(seed)} % 3) + 1;
         wr(ADDR_WD_CFG, {1'b0, mult[4:0], r[1:0]});
         wait_lo(1'b0, n);
         m = mult * step_cyc(r);
         chk(n >= m - step_cyc(r) - 4 && n <= m + step_cyc(r) + 8, 1);
         chk(rst_pin, 1'b1);
         rd(ADDR_FLAGS);
         chk(rd_val, 8'h80);
         rd(ADDR_FLAGS);
         chk(rd_val, 8'h00);
         chk(irq_pin, 1'b0);
         if (r[0])
            kick_pin();
         else
            wr(ADDR_WD_CFG, 8'h00);
         cyc(5);
         chk(irq_pin, 1'b1);
         cyc(m + step_cyc(r) + 10);
         chk(irq_pin, 1'b1);
      end
      wr(ADDR_WD_CFG, 8'h08);
      for (int i = 0; i < 6; i++)
      begin
         cyc(8);
         if (i == 3)
            wr(ADDR_WD_CFG, 8'h08);
         else
            kick_pin();
      end
      chk(irq_pin, 1'b1);
      wait_lo(1'b0, n);
      chk(n >= TICK && n <= 2 * TICK + TICK + 8, 1);
      wr(ADDR_WD_CFG, 8'h00);
      for (int j = 0; j < 3; j++)
      begin
         aux = (j == 0) ? 9'h1ff : ((j == 1) ? 9'h17f : 9'h07f);
         set_aux(aux);
         wr(ADDR_WD_CFG, 8'h84);
         wait_lo(1'b1, n);
         chk(irq_pin, 1'b1);
         low_len(n);
         chk(n >= rec_cyc(aux) - 1 && n <= rec_cyc(aux) + 3, 1);
         chk(o_aux_bits, aux & 9'h1f0);
         rd(ADDR_WD_CFG);
         chk(rd_val, 8'h00);
      end
      set_aux(9'h000);
      i_reset_in_falling = 1'b0;
      cyc(3);
      i_reset_in_falling = 1'b1;
      m = 0;
      repeat (20)
      begin
         cyc(1);
         m = m + (rst_pin === 1'b0);
      end
      chk(m, 0);
      for (int k = 0; k < 3; k++)
      begin
         drv(k, 1'b1);
         if (k != 1)
            wait_lo(1'b1, n);
         cyc(10);
         drv(k, 1'b0);
         wait_lo(1'b1, n);
         low_len(n);
         chk(n >= TSTD - 1 && n <= TSTD + 9, 1);
      end
      // A power-on reset in mid-run must clear armed settings and the pending flag.
      set_aux(9'h1ff);
      wr(ADDR_WD_CFG, 8'h0d);
      i_rst_b = 1'b0;
      cyc(2);
      i_rst_b = 1'b1;
      chk(o_aux_bits, 9'h000);
      low_len(n);
      chk(n >= TSTD - 1 && n <= TSTD + 3, 1);
      rd(ADDR_WD_CFG);
      chk(rd_val, 8'h00);
      cyc(200);
      chk(irq_pin, 1'b1);
      rd(ADDR_FLAGS);
      chk(rd_val, 8'h00);
      finish_test();
   end
endmodule
